// *** shared/passthru_pkg.sv ***
// Constants and carrier types for the add-on side of the passive pass-through port
package passthru_pkg;

  localparam int          DATA_W       = 32;
  localparam int          BE_W         = 4;
  localparam int          REGION_W     = 2;
  localparam int          PHASE_CNT_W  = 8;
  localparam int          REG_ADDR_W   = 5;
  localparam logic [7:0]  OFF_PASS_DATA = 8'h2c;
  localparam logic [31:0] ADDR_STEP    = 32'h4;
  localparam logic [3:0]  BE_ALL_VALID = 4'h0;
  localparam logic [3:0]  BE_NONE      = 4'hf;

  typedef struct packed {
    logic [DATA_W-1:0]      addr;
    logic                   write;
    logic [REGION_W-1:0]    region;
    logic [PHASE_CNT_W-1:0] phases;
  } pass_req_t;

  typedef struct packed {
    logic [BE_W-1:0]   be_n;
    logic [DATA_W-1:0] data;
  } phase_t;

  typedef struct packed {
    logic                  select_n;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [BE_W-1:0]       local_byte_enable_n;
    logic                  rd_n;
    logic                  wr_n;
    logic                  pass_address_read_n;
    logic                  pass_phase_ready_n;
  } addon_bus_t;

  typedef struct packed {
    logic                pass_attention_n;
    logic                pass_multi_phase_n;
    logic [REGION_W-1:0] pass_region_id;
    logic                pass_direction_write;
    logic [BE_W-1:0]     pass_byte_valid_n;
  } pass_status_t;

endpackage

// *** design/passthru_passive_addon_port.sv ***
// Add-on side of the passive pass-through port: status, data port, phase FIFO
`timescale 1ns/1ps
module passthru_passive_addon_port
#(
  parameter int DEPTH = 8
)
(
  input  wire logic                      clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      post_en_i,
  input  wire passthru_pkg::pass_req_t   req_i,
  input  wire logic                      req_valid_i,
  output logic                           req_ready_o,
  input  wire passthru_pkg::phase_t      phase_i,
  input  wire logic                      phase_valid_i,
  output logic                           phase_ready_o,
  output passthru_pkg::phase_t           rdata_o,
  output logic                           rdata_valid_o,
  input  wire passthru_pkg::addon_bus_t  bus_i,
  input  wire logic [31:0]               dq_i,
  output logic [31:0]                    dq_o,
  output logic                           dq_oe_o,
  output passthru_pkg::pass_status_t     status_o,
  output logic [31:0]                    pass_address_holder_o
);
  import passthru_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [REG_ADDR_W-1:0] DATA_IDX = OFF_PASS_DATA[6:2];

  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_DONE} phase_state_t;

  typedef struct packed {
    phase_state_t           st;
    pass_status_t           status;
    logic [31:0]            addr;
    logic [PHASE_CNT_W-1:0] remain;
    logic [31:0]            dq;
    logic                   dq_oe;
    phase_t                 rdata;
    logic                   rvalid;
    logic                   req_rdy;
    logic                   ph_rdy;
    logic [DEPTH-1:0][BE_W+DATA_W-1:0] mem;
    logic [PTR_W-1:0]       wptr;
    logic [PTR_W-1:0]       rptr;
    logic [CNT_W-1:0]       cnt;
  } st_t;

  localparam st_t ST_RESET = '{
    st:      ST_IDLE,
    status:  '{pass_attention_n: 1'b1, pass_multi_phase_n: 1'b1,
               pass_region_id: '0, pass_direction_write: 1'b0,
               pass_byte_valid_n: BE_NONE},
    default: '0
  };

  st_t s_reg;
  st_t s_next;

  logic                   rd_hit;
  logic                   wr_hit;
  logic                   ready;
  logic                   push;
  logic                   pop;
  logic                   start;
  logic [PHASE_CNT_W-1:0] req_len;
  logic [PTR_W-1:0]       rptr_inc;
  logic [PTR_W-1:0]       wptr_inc;
  phase_t                 head;
  phase_t                 next_head;
  logic [31:0]            byte_mask;

  always_comb
  begin
    rd_hit    = !bus_i.select_n && bus_i.reg_addr == DATA_IDX && !bus_i.rd_n;
    wr_hit    = !bus_i.select_n && bus_i.reg_addr == DATA_IDX && !bus_i.wr_n;
    ready     = s_reg.st == ST_ACTIVE && !bus_i.pass_phase_ready_n;
    rptr_inc  = (s_reg.rptr == PTR_W'(DEPTH - 1)) ? '0 : s_reg.rptr + 1'b1;
    wptr_inc  = (s_reg.wptr == PTR_W'(DEPTH - 1)) ? '0 : s_reg.wptr + 1'b1;
    head      = s_reg.mem[s_reg.rptr];
    next_head = s_reg.mem[rptr_inc];
    push      = phase_valid_i && s_reg.ph_rdy;
    start     = req_valid_i && s_reg.req_rdy;
    // Write accesses drain on the data-port read, read accesses on ready
    pop = s_reg.st == ST_ACTIVE && s_reg.cnt != '0 &&
          (s_reg.status.pass_direction_write ? rd_hit : ready);
    req_len = (req_i.phases == '0) ? PHASE_CNT_W'(1) : req_i.phases;
    if (req_i.write && !post_en_i)
    begin
      req_len = PHASE_CNT_W'(1);
    end
    for (int b = 0; b < BE_W; b++)
    begin
      byte_mask[b*8 +: 8] = {8{!bus_i.local_byte_enable_n[b]}};
    end

    s_next = s_reg;

    // Pipelined data-port read
    s_next.dq_oe = rd_hit;
    if (rd_hit)
    begin
      s_next.dq = head.data;
    end

    // Add-on writes land in the read FIFO toward PCI
    s_next.rvalid = wr_hit;
    if (wr_hit)
    begin
      s_next.rdata.data = dq_i & byte_mask;
      s_next.rdata.be_n = bus_i.local_byte_enable_n;
    end

    if (push)
    begin
      s_next.mem[s_reg.wptr] = phase_i;
      s_next.wptr = wptr_inc;
    end
    if (pop)
    begin
      s_next.rptr = rptr_inc;
    end
    s_next.cnt = s_reg.cnt + CNT_W'(push) - CNT_W'(pop);

    case (s_reg.st)
      ST_IDLE:
      begin
        if (start)
        begin
          s_next.st     = ST_ACTIVE;
          s_next.addr   = req_i.addr;
          s_next.remain = req_len;
          s_next.status.pass_attention_n     = 1'b0;
          s_next.status.pass_region_id       = req_i.region;
          s_next.status.pass_direction_write = req_i.write;
          s_next.status.pass_multi_phase_n   = !(req_len > PHASE_CNT_W'(1));
          s_next.status.pass_byte_valid_n    = head.be_n;
        end
      end
      ST_ACTIVE:
      begin
        if (pop)
        begin
          s_next.status.pass_byte_valid_n = next_head.be_n;
        end
        if (ready)
        begin
          s_next.remain = s_reg.remain - 1'b1;
          s_next.status.pass_multi_phase_n =
            !(s_reg.remain > PHASE_CNT_W'(2));
          if (s_reg.status.pass_direction_write && s_reg.remain > PHASE_CNT_W'(1))
          begin
            s_next.addr = s_reg.addr + ADDR_STEP;
          end
          if (s_reg.remain <= PHASE_CNT_W'(1))
          begin
            s_next.status.pass_attention_n = 1'b1;
            s_next.st = ST_DONE;
          end
        end
      end
      ST_DONE:
      begin
        s_next.st = ST_IDLE;
      end
      default:
      begin
        s_next.st = ST_IDLE;
      end
    endcase

    s_next.req_rdy = s_next.st == ST_IDLE && s_next.cnt != '0;
    // Without posting a single location is taken until the add-on drains it and the access has returned to idle
    s_next.ph_rdy = s_next.cnt < FULL_CNT &&
                    (post_en_i || (s_next.cnt == '0 && s_next.st == ST_IDLE));
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s_reg <= ST_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign status_o              = s_reg.status;
  assign req_ready_o           = s_reg.req_rdy;
  assign phase_ready_o         = s_reg.ph_rdy;
  assign rdata_o               = s_reg.rdata;
  assign rdata_valid_o         = s_reg.rvalid;
  assign pass_address_holder_o = s_reg.addr;
  // Address read is unpipelined, so it bypasses the output register
  assign dq_o    = !bus_i.pass_address_read_n ? s_reg.addr : s_reg.dq;
  assign dq_oe_o = s_reg.dq_oe || !bus_i.pass_address_read_n;

  a_addr_store: assert property (@(posedge clk_i) disable iff (srst_i)
    start |=> pass_address_holder_o == $past(req_i.addr))
    else $error("held address not stored at access start");

  a_status_next: assert property (@(posedge clk_i) disable iff (srst_i)
    start |=> !status_o.pass_attention_n
              && status_o.pass_region_id == $past(req_i.region)
              && status_o.pass_direction_write == $past(req_i.write))
    else $error("status not presented on edge after start");

  a_multi_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    s_reg.st == ST_ACTIVE |->
      status_o.pass_multi_phase_n == !(s_reg.remain > PHASE_CNT_W'(1)))
    else $error("multi-phase flag disagrees with phases left");

  a_post_single: assert property (@(posedge clk_i) disable iff (srst_i)
    start && req_i.write && !post_en_i |=> status_o.pass_multi_phase_n [*2])
    else $error("multi-phase asserted with posting off");

  a_final_end: assert property (@(posedge clk_i) disable iff (srst_i)
    ready && s_reg.remain == PHASE_CNT_W'(1) |=> status_o.pass_attention_n ##1 req_ready_o
      || s_reg.cnt == '0)
    else $error("attention not dropped after final ready");

  a_wait_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    s_reg.st == ST_ACTIVE && bus_i.pass_phase_ready_n |=>
      !status_o.pass_attention_n && s_reg.remain == $past(s_reg.remain))
    else $error("phase ended without ready");

  a_read_drive: assert property (@(posedge clk_i) disable iff (srst_i)
    rd_hit |=> s_reg.dq_oe && s_reg.dq == $past(head.data))
    else $error("data port not driven one clock after read strobe");

  a_write_capture: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_hit |=> rdata_valid_o && rdata_o.data == ($past(dq_i) & $past(byte_mask)))
    else $error("data bus not captured after write strobe");

  a_addr_step: assert property (@(posedge clk_i) disable iff (srst_i)
    ready && s_reg.status.pass_direction_write && s_reg.remain > PHASE_CNT_W'(1)
      |=> pass_address_holder_o == $past(pass_address_holder_o) + ADDR_STEP)
    else $error("held address not advanced in write burst");

  a_reset_quiet: assert property (@(posedge clk_i)
    srst_i |=> status_o.pass_attention_n && !s_reg.dq_oe)
    else $error("reset left attention or data bus active");

  a_addr_bypass: assert property (@(posedge clk_i) disable iff (srst_i)
    !bus_i.pass_address_read_n |-> dq_oe_o && dq_o == pass_address_holder_o)
    else $error("held address not on data bus during address read");

  a_region_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    s_reg.st == ST_ACTIVE |=>
      status_o.pass_region_id == $past(status_o.pass_region_id))
    else $error("region identifier changed during access");

  a_dir_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    s_reg.st == ST_ACTIVE |=>
      status_o.pass_direction_write == $past(status_o.pass_direction_write))
    else $error("direction changed during access");

  a_byte_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    s_reg.st == ST_ACTIVE && !pop |=>
      status_o.pass_byte_valid_n == $past(status_o.pass_byte_valid_n))
    else $error("byte-valid outputs moved without a transfer");

  a_byte_advance: assert property (@(posedge clk_i) disable iff (srst_i)
    pop |=> status_o.pass_byte_valid_n == $past(next_head.be_n))
    else $error("byte-valid outputs not advanced to next phase");

  a_done_idle: assert property (@(posedge clk_i) disable iff (srst_i)
    s_reg.st == ST_DONE |=> s_reg.st == ST_IDLE && status_o.pass_attention_n)
    else $error("access not closed one clock after attention dropped");

  a_busy_refuse: assert property (@(posedge clk_i) disable iff (srst_i)
    s_reg.st != ST_IDLE |-> !req_ready_o)
    else $error("new access offered while one is pending");

  a_idle_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
    s_reg.st == ST_IDLE |-> status_o.pass_attention_n)
    else $error("attention asserted with no access pending");

  a_bus_release: assert property (@(posedge clk_i) disable iff (srst_i)
    !rd_hit |=> !s_reg.dq_oe)
    else $error("data port still driven after read strobe released");

  a_write_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
    !wr_hit |=> !rdata_valid_o)
    else $error("word captured without write strobe");

  a_fifo_step: assert property (@(posedge clk_i) disable iff (srst_i)
    push && !pop |=> s_reg.cnt == $past(s_reg.cnt) + 1'b1)
    else $error("phase not counted into the buffer");

  a_post_refuse: assert property (@(posedge clk_i) disable iff (srst_i)
    push && !post_en_i |=> !phase_ready_o)
    else $error("second location offered with posting off");

  a_phase_count: assert property (@(posedge clk_i) disable iff (srst_i)
    ready |=> s_reg.remain == $past(s_reg.remain) - 1'b1)
    else $error("phase count not stepped on ready");

endmodule

// *** bench/addon_partner.sv ***
// Add-on memory-side model answering pass-through accesses
`timescale 1ns/1ps
module addon_partner
(
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire logic                       slow_i,
  input  wire passthru_pkg::pass_status_t st_i,
  input  wire logic [31:0]                dev_dq_i,
  output passthru_pkg::addon_bus_t        bus_o,
  output logic [31:0]                     dq_o
);
  import passthru_pkg::*;
  logic [31:0] addr_seen;
  logic [31:0] got [0:63];
  int          n_got = 0;
  int          n_put = 0;
  logic        rd_q = 1'b0;
  logic        last;

  // Store read data one clock after the strobe edge
  always @(posedge clk_i)
  begin
    if (rd_q)
    begin
      got[n_got] = dev_dq_i;
      n_got++;
    end
    rd_q = !bus_o.rd_n && !bus_o.select_n;
  end

  // All changes made at the falling edge
  initial
  begin
    bus_o = '1;
    dq_o  = 32'h0;
    forever
    begin
      @(negedge clk_i);
      if (!srst_i && !st_i.pass_attention_n)
      begin
        bus_o.pass_address_read_n = 1'b0;
        @(posedge clk_i);
        addr_seen = dev_dq_i;
        @(negedge clk_i);
        bus_o = '1;
        @(negedge clk_i);
        last = 1'b0;
        while (!last)
        begin
          last = st_i.pass_multi_phase_n;
          bus_o.select_n = 1'b0;
          bus_o.reg_addr = OFF_PASS_DATA[6:2];
          bus_o.local_byte_enable_n = 4'h0;
          bus_o.pass_phase_ready_n = 1'b0;
          if (st_i.pass_direction_write)
            bus_o.rd_n = 1'b0;
          else
          begin
            bus_o.wr_n = 1'b0;
            dq_o = 32'hc0de0000 + 32'(n_put);
            n_put++;
          end
          @(negedge clk_i);
          if (slow_i || last)
          begin
            bus_o = '1;
            dq_o = ~dq_o;
            if (!last)
              @(negedge clk_i);
          end
        end
        @(negedge clk_i);
      end
    end
  end
endmodule

// *** bench/passthru_passive_addon_port_tb_top.sv ***
// Self-checking bench for the pass-through add-on port
`timescale 1ns/1ps
module passthru_passive_addon_port_tb_top;
  import passthru_pkg::*;
  logic         clk_i = 1'b0;
  logic         srst_i = 1'b1;
  logic         post_en_i = 1'b1;
  logic         slow_i = 1'b0;
  pass_req_t    req_i = '0;
  logic         req_valid_i = 1'b0;
  phase_t       phase_i = '0;
  logic         phase_valid_i = 1'b0;
  logic         req_ready_o;
  logic         phase_ready_o;
  logic         rdata_valid_o;
  logic         dq_oe_o;
  phase_t       rdata_o;
  addon_bus_t   bus_i;
  logic [31:0]  pdq;
  logic [31:0]  dq_o;
  logic [31:0]  line;
  logic [31:0]  holder;
  pass_status_t status_o;
  int           err_count = 0;
  int           n_tests = 0;
  int           n_rd = 0;

  assign line = dq_oe_o ? dq_o : pdq;

  initial
    forever #2 clk_i = ~clk_i;

  passthru_passive_addon_port #(.DEPTH(8)) DUT
  (
    .clk_i(clk_i), .srst_i(srst_i), .post_en_i(post_en_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .phase_i(phase_i),
    .phase_valid_i(phase_valid_i), .phase_ready_o(phase_ready_o), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o), .bus_i(bus_i), .dq_i(line), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .status_o(status_o), .pass_address_holder_o(holder)
  );

  addon_partner partner
  (
    .clk_i(clk_i), .srst_i(srst_i), .slow_i(slow_i), .st_i(status_o),
    .dev_dq_i(line), .bus_o(bus_i), .dq_o(pdq)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_i)
    if (rdata_valid_o === 1'b1)
    begin
      check(rdata_o.data, 32'hc0de0000 + 32'(n_rd));
      check(32'(rdata_o.be_n), 32'h0);
      n_rd++;
    end

  task automatic access(input logic [31:0] a, input logic w, input logic [1:0] r,
                        input int n, input logic [3:0] be0);
    int           np;
    int           g0;
    int           r0;
    int           k;
    pass_status_t exp;
    np = post_en_i ? n : 1;
    g0 = partner.n_got;
    r0 = n_rd;
    for (k = 0; k < np; k++)
    begin
      @(negedge clk_i);
      phase_i = '{(k == 0) ? be0 : 4'(k), 32'h5a000000 + 32'(k)};
      phase_valid_i = 1'b1;
      @(posedge clk_i);
      while (!phase_ready_o)
        @(posedge clk_i);
    end
    @(negedge clk_i);
    phase_valid_i = 1'b0;
    check(32'(phase_ready_o), 32'(post_en_i));
    req_i = '{a, w, r, 8'(n)};
    req_valid_i = 1'b1;
    @(posedge clk_i);
    while (!req_ready_o)
      @(posedge clk_i);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    @(negedge clk_i);
    exp = '{1'b0, np == 1, r, w, be0};
    check(32'(status_o), 32'(exp));
    for (k = 0; k < 300 && status_o.pass_attention_n !== 1'b1; k++)
      @(negedge clk_i);
    check(32'(status_o.pass_attention_n), 32'h1);
    repeat (3) @(negedge clk_i);
    check(partner.addr_seen, a);
    check(32'(dq_oe_o), 32'h0);
    check(32'(req_ready_o), 32'h0);
    if (w)
    begin
      check(32'(partner.n_got - g0), 32'(np));
      for (k = 0; k < np; k++)
        check(partner.got[g0 + k], 32'h5a000000 + 32'(k));
      if (np > 1)
        check(holder, a + ADDR_STEP * 32'(np - 1));
    end
    else
      check(32'(n_rd - r0), 32'(n));
  endtask

  initial
  begin
    #40000;
    err_count++;
    complete_run();
  end

  initial
  begin
    repeat (16) @(negedge clk_i);
    srst_i = 1'b0;
    check(32'(status_o), 32'h18f);
    check(32'(dq_oe_o), 32'h0);
    access(32'h00001000, 1'b0, 2'h2, 1, 4'h0);
    access(32'h00002000, 1'b1, 2'h3, 4, 4'h3);
    slow_i = 1'b1;
    access(32'h00003000, 1'b1, 2'h0, 3, 4'h1);
    access(32'h00004000, 1'b0, 2'h1, 3, 4'h0);
    slow_i = 1'b0;
    post_en_i = 1'b0;
    access(32'h00005000, 1'b1, 2'h1, 3, 4'h0);
    complete_run();
  end
endmodule
